// file: rtl/tbc_pkg.sv
// Shared constants and types for the timer b unit counter/capture block
package tbc_pkg;

  localparam int          CNT_W         = 16;
  localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] CMP_RESET     = 16'h0000;

  // source_select field codes
  localparam logic [1:0]  SRC_DIV1      = 2'h0;
  localparam logic [1:0]  SRC_DIV2      = 2'h1;
  localparam logic [1:0]  SRC_SISTER    = 2'h2;
  localparam logic [1:0]  SRC_EVENT     = 2'h3;
  localparam logic [1:0]  SRC_RESET     = 2'h0;

  // Mode field codes; the remaining five codes are decoded as idle here
  localparam logic [2:0]  MODE_PERIODIC = 3'h0;
  localparam logic [2:0]  MODE_TIMEOUT  = 3'h1;
  localparam logic [2:0]  MODE_TOP_REACHED_FLAG_EVT = 3'h2;
  localparam logic [2:0]  MODE_RESET    = 3'h0;

  // Flag positions in the write-one-to-clear vector
  localparam int          FLAG_TOP_BIT  = 0;
  localparam int          FLAG_WRAP_BIT = 1;

  // Prescaler width for the divide-by-two output
  localparam int          PRESC_W       = 1;

  typedef enum logic {
    TO_FREEZE,
    TO_COUNT
  } tbc_to_state_t;

endpackage : tbc_pkg

// file: rtl/tbc_edge_det.sv
// Event input synchroniser and edge detector
module tbc_edge_det
  import tbc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_event,
  output logic      o_rise,
  output logic      o_fall
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic next_level;
  logic next_rise;
  logic next_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // A change counts only once the second and third stages agree, which filters
  // single-cycle glitches; pulses shorter than two cycles may be lost.
  always_comb begin
    next_level = level;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    if ((sync2 == sync3) && (sync3 != level)) begin
      next_level = sync3;
      next_rise  = sync3;
      next_fall  = ~sync3;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1  <= 1'b0;
      sync2  <= 1'b0;
      sync3  <= 1'b0;
      level  <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      sync1  <= i_event;
      sync2  <= sync1;
      sync3  <= sync2;
      level  <= next_level;
      o_rise <= next_rise;
      o_fall <= next_fall;
    end
  end

endmodule // tbc_edge_det

// file: rtl/tbc_tick_sel.sv
// Count clock selection: prescaler, sister timer tick or event tick
module tbc_tick_sel
  import tbc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_source_select,
  input  wire logic       i_sister_timer_tick,
  input  wire logic       i_event_tick,
  output logic            o_timer_tick
);

  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] next_presc;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler held at zero while disabled so the first tick phase is repeatable
  always_comb begin
    next_presc = i_enable ? presc + 1'b1 : '0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end

  always_comb begin
    o_timer_tick = 1'b0;
    case (i_source_select)
      SRC_DIV1:   o_timer_tick = i_enable;
      SRC_DIV2:   o_timer_tick = i_enable & (&presc);
      SRC_SISTER: o_timer_tick = i_enable & i_sister_timer_tick;
      SRC_EVENT:  o_timer_tick = i_enable & i_event_tick;
      default:    o_timer_tick = 1'b0;
    endcase
  end

endmodule // tbc_tick_sel

// file: rtl/tbc_timer.sv
// Timer b unit: 16-bit counter with periodic, time-out check and capture modes
//
// Overview of operation
// - Count range runs from 0x0000 bottom to 0xFFFF maximum; top is sequence peak.
// - Count clock comes from prescaler, sister timer tick or event channel.
// - After reset the unit sits in periodic interrupt mode, one of three.
// - With wave output enabled the pin shows the waveform, not the port value.
// - Enable set to one starts counting at the selected tick rate.
// - Periodic mode counts to compare value, flags top and restarts from bottom.
// - Top lowered below count: run to maximum, flag wrap, restart from bottom.
// - Time-out mode starts on first edge, stops on next, freezes until restart.
// - Edge select chooses start and stop polarity in time-out mode.
// - Time-out mode flags top when top is reached before the stop edge.
// - Time-out mode flags wrap at maximum when top was lowered, then restarts.
// - While frozen, count/compare reads and run writes change nothing.
// - Capture mode free-runs; each event copies count to compare and flags top.
// - Capture edge is selectable as rising or falling.
// - Capture mode clears top flag when software reads compare low byte.
// - Capture mode flags wrap each time the count reaches maximum.
module tbc_timer
  import tbc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Control writes
  input  wire logic        i_ctrl_wr,
  input  wire logic        i_ctrl_enable,
  input  wire logic [1:0]  i_ctrl_source_select,
  input  wire logic [2:0]  i_ctrl_mode,
  input  wire logic        i_ctrl_wave_out_enable,
  input  wire logic        i_ctrl_init_level,
  input  wire logic        i_ctrl_edge_select,
  // Count and compare access
  input  wire logic        i_cnt_wr,
  input  wire logic [15:0] i_cnt_wdata,
  input  wire logic        i_cmp_wr,
  input  wire logic [15:0] i_cmp_wdata,
  input  wire logic        i_cmp_lo_rd,
  input  wire logic        i_run_wr,
  input  wire logic        i_run_wdata,
  input  wire logic [1:0]  i_flag_clr,
  // Clock sources and event input
  input  wire logic        i_sister_timer_tick,
  input  wire logic        i_event,
  // Port side of the wave pin
  input  wire logic        i_port_out,
  input  wire logic        i_port_dir,
  // Status and results
  output logic             o_enable,
  output logic [1:0]       o_source_select,
  output logic [2:0]       o_mode,
  output logic             o_edge_select,
  output logic [15:0]      o_count_value,
  output logic [15:0]      o_compare_value,
  output logic             o_run,
  output logic             o_top_reached_flag,
  output logic             o_wrap_flag,
  output logic             o_top_event,
  output logic             o_wrap_event,
  output logic             o_wave_pin,
  output logic             o_wave_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Control settings

  logic        enable;
  logic [1:0]  source_select;
  logic [2:0]  mode;
  logic        wave_out_enable;
  logic        init_level;
  logic        edge_select;
  logic        next_enable;
  logic [1:0]  next_source_select;
  logic [2:0]  next_mode;
  logic        next_wave_out_enable;
  logic        next_init_level;
  logic        next_edge_select;

  always_comb begin
    next_enable          = enable;
    next_source_select   = source_select;
    next_mode            = mode;
    next_wave_out_enable = wave_out_enable;
    next_init_level      = init_level;
    next_edge_select     = edge_select;
    if (i_ctrl_wr) begin
      next_enable          = i_ctrl_enable;
      next_source_select   = i_ctrl_source_select;
      next_mode            = i_ctrl_mode;
      next_wave_out_enable = i_ctrl_wave_out_enable;
      next_init_level      = i_ctrl_init_level;
      next_edge_select     = i_ctrl_edge_select;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable          <= 1'b0;
      source_select   <= SRC_RESET;
      mode            <= MODE_RESET;
      wave_out_enable <= 1'b0;
      init_level      <= 1'b0;
      edge_select     <= 1'b0;
    end else begin
      enable          <= next_enable;
      source_select   <= next_source_select;
      mode            <= next_mode;
      wave_out_enable <= next_wave_out_enable;
      init_level      <= next_init_level;
      edge_select     <= next_edge_select;
    end
  end

  assign o_enable        = enable;
  assign o_source_select = source_select;
  assign o_mode          = mode;
  assign o_edge_select   = edge_select;

  ////////////////////////////////////////////////////////////////////////////////
  // Event edges and count tick

  logic ev_rise;
  logic ev_fall;
  logic timer_tick;
  logic start_edge;
  logic stop_edge;

  // Needs events held past one clock, else the filter drops them
  tbc_edge_det u_edge (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_event(i_event),
    .o_rise (ev_rise),
    .o_fall (ev_fall)
  );

  tbc_tick_sel u_tick (
    .i_clk              (i_clk),
    .i_rst              (i_rst),
    .i_enable           (enable),
    .i_source_select    (source_select),
    .i_sister_timer_tick(i_sister_timer_tick),
    .i_event_tick       (ev_rise),
    .o_timer_tick       (timer_tick)
  );

  // Edge select zero: start or capture on rising, stop on falling
  assign start_edge = edge_select ? ev_fall : ev_rise;
  assign stop_edge  = edge_select ? ev_rise : ev_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, compare and time-out state

  // One count step: {top hit, wrap hit, next count}
  function automatic logic [17:0] count_step(input logic [15:0] cnt,
                                             input logic [15:0] top,
                                             input logic        use_top);
    logic [17:0] res;
    res = {2'b00, cnt + 16'h0001};
    if (use_top && (cnt == top)) begin
      res = {2'b10, CNT_BOTTOM};
    end else if (cnt == CNT_MAX) begin
      res = {2'b01, CNT_BOTTOM};
    end
    return res;
  endfunction

  logic [15:0]   count_value;
  logic [15:0]   compare_value;
  tbc_to_state_t to_state;
  logic          wave;
  logic [15:0]   next_count_value;
  logic [15:0]   next_compare_value;
  tbc_to_state_t next_to_state;
  logic          next_wave;
  logic          top_hit;
  logic          wrap_hit;
  logic [17:0]   step;

  always_comb begin
    next_count_value   = count_value;
    next_compare_value = compare_value;
    next_to_state      = to_state;
    next_wave          = wave;
    top_hit            = 1'b0;
    wrap_hit           = 1'b0;
    step               = count_step(count_value, compare_value, mode != MODE_TOP_REACHED_FLAG_EVT);
    if (!enable) begin
      // Waveform parks at its chosen initial level while stopped
      next_wave     = init_level;
      next_to_state = TO_FREEZE;
    end else begin
      case (mode)
        MODE_PERIODIC: begin
          if (timer_tick) begin
            top_hit          = step[17];
            wrap_hit         = step[16];
            next_count_value = step[15:0];
            if (step[17]) begin
              next_wave = ~wave;
            end
          end
        end
        MODE_TIMEOUT: begin
          case (to_state)
            TO_FREEZE: begin
              if (start_edge) begin
                next_to_state    = TO_COUNT;
                next_count_value = CNT_BOTTOM;
              end
            end
            TO_COUNT: begin
              if (stop_edge) begin
                next_to_state = TO_FREEZE;
              end else if (timer_tick) begin
                top_hit          = step[17];
                wrap_hit         = step[16];
                next_count_value = step[15:0];
              end
              if (i_run_wr && !i_run_wdata) begin
                next_to_state = TO_FREEZE;
              end
            end
            default: next_to_state = TO_FREEZE;
          endcase
        end
        MODE_TOP_REACHED_FLAG_EVT: begin
          if (timer_tick) begin
            wrap_hit         = step[16];
            next_count_value = step[15:0];
          end
          if (start_edge) begin
            next_compare_value = count_value;
            top_hit            = 1'b1;
          end
        end
        default: begin
          next_count_value = count_value;
        end
      endcase
    end
    // Software access takes priority over counting and capture
    if (i_cnt_wr) begin
      next_count_value = i_cnt_wdata;
    end
    if (i_cmp_wr) begin
      next_compare_value = i_cmp_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_value   <= CNT_RESET;
      compare_value <= CMP_RESET;
      to_state      <= TO_FREEZE;
      wave          <= 1'b0;
    end else begin
      count_value   <= next_count_value;
      compare_value <= next_compare_value;
      to_state      <= next_to_state;
      wave          <= next_wave;
    end
  end

  assign o_count_value   = count_value;
  assign o_compare_value = compare_value;
  // Run write in freeze is ignored in the state logic above
  assign o_run = (mode == MODE_TIMEOUT) ? (enable && (to_state == TO_COUNT)) : enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and event pulses

  logic top_flag;
  logic wrap_flag;
  logic next_top_flag;
  logic next_wrap_flag;
  logic next_wave_pin;
  logic next_wave_pin_oe;

  always_comb begin
    next_top_flag  = top_flag;
    next_wrap_flag = wrap_flag;
    if (i_flag_clr[FLAG_TOP_BIT]) begin
      next_top_flag = 1'b0;
    end
    if (i_flag_clr[FLAG_WRAP_BIT]) begin
      next_wrap_flag = 1'b0;
    end
    // Only capture mode reads clear; a frozen time-out read is harmless
    if (i_cmp_lo_rd && (mode == MODE_TOP_REACHED_FLAG_EVT)) begin
      next_top_flag = 1'b0;
    end
    // A new event in the clearing cycle wins so it is never lost
    if (top_hit) begin
      next_top_flag = 1'b1;
    end
    if (wrap_hit) begin
      next_wrap_flag = 1'b1;
    end
    // Waveform overrides the port output register when enabled
    next_wave_pin    = wave_out_enable ? next_wave : i_port_out;
    next_wave_pin_oe = wave_out_enable | i_port_dir;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      top_flag      <= 1'b0;
      wrap_flag     <= 1'b0;
      o_top_event   <= 1'b0;
      o_wrap_event  <= 1'b0;
      o_wave_pin    <= 1'b0;
      o_wave_pin_oe <= 1'b0;
    end else begin
      top_flag      <= next_top_flag;
      wrap_flag     <= next_wrap_flag;
      o_top_event   <= top_hit;
      o_wrap_event  <= wrap_hit;
      o_wave_pin    <= next_wave_pin;
      o_wave_pin_oe <= next_wave_pin_oe;
    end
  end

  assign o_top_reached_flag = top_flag;
  assign o_wrap_flag        = wrap_flag;

endmodule // tbc_timer

// file: testbench/tbc_timer_assertions.sv
// Assertion checker for the timer b counter block
module tbc_timer_assertions
  import tbc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ctrl_wr,
  input wire logic        i_cnt_wr,
  input wire logic        i_cmp_wr,
  input wire logic        i_cmp_lo_rd,
  input wire logic [1:0]  i_flag_clr,
  input wire logic        o_enable,
  input wire logic [1:0]  o_source_select,
  input wire logic [2:0]  o_mode,
  input wire logic [15:0] o_count_value,
  input wire logic [15:0] o_compare_value,
  input wire logic        o_run,
  input wire logic        o_top_reached_flag,
  input wire logic        o_wrap_flag,
  input wire logic        o_top_event,
  input wire logic        o_wrap_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic per_run;
  // Software writes win over counting, so they are kept out of the count relations
  assign per_run = o_enable && o_mode == MODE_PERIODIC && o_source_select == SRC_DIV1
                   && !i_ctrl_wr && !i_cnt_wr && !i_cmp_wr;
  a_per_count_up: assert property (per_run && o_count_value != o_compare_value
    && o_count_value != CNT_MAX |=> o_count_value == $past(o_count_value) + 16'h0001)
    else $error("count did not advance by one");
  a_per_top_restart: assert property (per_run && o_count_value == o_compare_value
    |=> o_count_value == CNT_BOTTOM && o_top_reached_flag) else $error("no restart at top");
  a_per_wrap_max: assert property (per_run && o_count_value == CNT_MAX
    && o_compare_value != CNT_MAX |=> o_count_value == CNT_BOTTOM && o_wrap_flag)
    else $error("no wrap at maximum");
  a_top_event_follows: assert property ($rose(o_top_reached_flag) |-> o_top_event)
    else $error("top event missing after top flag");
  a_wrap_event_follows: assert property ($rose(o_wrap_flag) |-> o_wrap_event)
    else $error("wrap event missing after wrap flag");
  a_wrap_event_single: assert property (o_wrap_event |=> !o_wrap_event)
    else $error("wrap event longer than one cycle");
  a_hold_disabled: assert property (!o_enable && !i_cnt_wr && !i_ctrl_wr
    |=> $stable(o_count_value)) else $error("count moved while disabled");
  a_top_flag_sticky: assert property (o_top_reached_flag && !i_flag_clr[FLAG_TOP_BIT]
    && !(o_mode == MODE_TOP_REACHED_FLAG_EVT && i_cmp_lo_rd) |=> o_top_reached_flag)
    else $error("top flag dropped without clear");
  a_wrap_flag_clear: assert property (i_flag_clr[FLAG_WRAP_BIT] && !o_enable
    |=> !o_wrap_flag) else $error("wrap flag not cleared");
  a_run_follows_enable: assert property (o_mode != MODE_TIMEOUT |-> o_run == o_enable)
    else $error("run status differs from enable");
endmodule  // tbc_timer_assertions

bind tbc_timer tbc_timer_assertions chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_ctrl_wr(i_ctrl_wr), .i_cnt_wr(i_cnt_wr),
  .i_cmp_wr(i_cmp_wr), .i_cmp_lo_rd(i_cmp_lo_rd), .i_flag_clr(i_flag_clr),
  .o_enable(o_enable), .o_source_select(o_source_select), .o_mode(o_mode),
  .o_count_value(o_count_value), .o_compare_value(o_compare_value), .o_run(o_run),
  .o_top_reached_flag(o_top_reached_flag), .o_wrap_flag(o_wrap_flag),
  .o_top_event(o_top_event), .o_wrap_event(o_wrap_event)
);

// file: testbench/tbc_evt_model.sv
// Event fabric channel and sister timer tick source
module tbc_evt_model
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_want,
  output logic      o_event,
  output logic      o_sister_timer_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] held;
  logic [1:0] div;
  // A new level is passed on only once the old one has stood three cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_event <= 1'b0;
      held <= 2'h3;
      div <= 2'h0;
      o_sister_timer_tick <= 1'b0;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      o_sister_timer_tick <= (div == 2'h2);
      if (i_want != o_event && held >= 2'h2) begin
        o_event <= i_want;
        held <= 2'h0;
      end else if (held != 2'h3) begin
        held <= held + 2'h1;
      end
    end
  end
endmodule  // tbc_evt_model

// file: testbench/tbc_timer_tb_top.sv
// Self-checking testbench for the timer b counter block
module tbc_timer_tb_top
  import tbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_CNT = 0, K_CMP = 1, K_CLR = 2, K_RDLO = 3, K_RUN = 4;
  logic        i_clk, i_rst, i_ctrl_wr, i_ctrl_enable, i_ctrl_wave_out_enable;
  logic        i_ctrl_init_level, i_ctrl_edge_select, i_cnt_wr, i_cmp_wr, i_cmp_lo_rd;
  logic        i_run_wr, i_run_wdata, i_port_out, i_port_dir, ev_want, i_event;
  logic        i_sister_timer_tick, o_enable, o_run, o_top_reached_flag, o_wrap_flag;
  logic        o_top_event, o_wrap_event, o_wave_pin, o_wave_pin_oe, w0, o_edge_select;
  logic [1:0]  i_ctrl_source_select, i_flag_clr, o_source_select;
  logic [2:0]  i_ctrl_mode, o_mode;
  logic [15:0] i_cnt_wdata, i_cmp_wdata, o_count_value, o_compare_value, snap;
  int          mismatches, checks_done, cycles, n;

  tbc_timer dut_u (
    .i_clk, .i_rst, .i_ctrl_wr, .i_ctrl_enable, .i_ctrl_source_select, .i_ctrl_mode,
    .i_ctrl_wave_out_enable, .i_ctrl_init_level, .i_ctrl_edge_select, .i_cnt_wr,
    .i_cnt_wdata, .i_cmp_wr, .i_cmp_wdata, .i_cmp_lo_rd, .i_run_wr, .i_run_wdata,
    .i_flag_clr, .i_sister_timer_tick, .i_event, .i_port_out, .i_port_dir, .o_enable,
    .o_source_select, .o_mode, .o_edge_select, .o_count_value, .o_compare_value, .o_run,
    .o_top_reached_flag, .o_wrap_flag, .o_top_event, .o_wrap_event, .o_wave_pin,
    .o_wave_pin_oe
  );
  tbc_evt_model evt_u (.i_clk, .i_rst, .i_want(ev_want), .o_event(i_event),
    .o_sister_timer_tick(i_sister_timer_tick));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // The full sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic ctl(input logic [8:0] f);
    @(posedge i_clk);
    {i_ctrl_enable, i_ctrl_source_select, i_ctrl_mode} <= f[8:3];
    {i_ctrl_wave_out_enable, i_ctrl_init_level, i_ctrl_edge_select} <= f[2:0];
    i_ctrl_wr <= 1'b1;
    @(posedge i_clk);
    i_ctrl_wr <= 1'b0;
    #1;
  endtask
  task automatic poke(input int k, input logic [15:0] v);
    @(posedge i_clk);
    case (k)
      K_CNT: i_cnt_wr <= 1'b1;
      K_CMP: i_cmp_wr <= 1'b1;
      K_CLR: i_flag_clr <= v[1:0];
      K_RDLO: i_cmp_lo_rd <= 1'b1;
      default: i_run_wr <= 1'b1;
    endcase
    {i_cnt_wdata, i_cmp_wdata, i_run_wdata} <= {v, v, v[0]};
    @(posedge i_clk);
    {i_cnt_wr, i_cmp_wr, i_cmp_lo_rd, i_run_wr, i_flag_clr} <= 6'h00;
    #1;
  endtask
  // Returns one edge after the request, when the channel level has moved
  task automatic evt(input logic lvl);
    @(posedge i_clk);
    ev_want <= lvl;
    cyc(1);
  endtask
  task automatic wwrap(input int lim);
    for (n = 0; o_wrap_flag !== 1'b1 && n < lim; n++) cyc(1);
  endtask

  initial begin
    {i_ctrl_wr, i_ctrl_enable, i_ctrl_wave_out_enable, i_ctrl_init_level} = 4'h0;
    {i_ctrl_edge_select, i_cnt_wr, i_cmp_wr, i_cmp_lo_rd, i_run_wr, i_run_wdata} = 6'h00;
    {i_ctrl_source_select, i_flag_clr, i_ctrl_mode, i_cnt_wdata, i_cmp_wdata} = 39'h0;
    {i_port_out, i_port_dir, ev_want, i_rst} = 4'h9;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc(3);
    chk("mode", 16'(o_mode), 16'(MODE_PERIODIC));
    chk("flags", 16'({o_top_reached_flag, o_wrap_flag}), 16'h0000);
    poke(K_CMP, 16'h0003);
    ctl({1'b1, SRC_DIV1, MODE_PERIODIC, 3'b100});
    cyc(3);
    chk("count", o_count_value, 16'h0003);
    w0 = o_wave_pin;
    cyc(1);
    chk("top", 16'({o_count_value == CNT_BOTTOM, o_top_reached_flag}), 16'h0003);
    chk("top_ev", 16'(o_top_event), 16'h0001);
    cyc(1);
    chk("pin", 16'({w0, o_wave_pin, o_wave_pin_oe}), 16'h0003);
    poke(K_CNT, 16'hFFF0);
    wwrap(40);
    chk("wrap_n", 16'(n), 16'h0010);
    chk("wrap_cnt", o_count_value, CNT_BOTTOM);
    chk("wrap_ev", 16'(o_wrap_event), 16'h0001);
    ctl({1'b0, SRC_DIV1, MODE_PERIODIC, 3'b000});
    cyc(6);
    chk("sticky", 16'({o_top_reached_flag, o_wrap_flag}), 16'h0003);
    chk("pin_off", 16'({o_wave_pin, o_wave_pin_oe}), 16'h0002);
    poke(K_CLR, 16'h0003);
    chk("cleared", 16'({o_top_reached_flag, o_wrap_flag}), 16'h0000);
    poke(K_CMP, CNT_MAX);
    poke(K_CNT, 16'h0000);
    ctl({1'b1, SRC_DIV2, MODE_PERIODIC, 3'b000});
    cyc(11);
    chk("div2", o_count_value, 16'h0005);
    ctl({1'b1, SRC_SISTER, MODE_PERIODIC, 3'b000});
    snap = o_count_value;
    cyc(30);
    chk("sister", 16'((o_count_value - snap) inside {[16'h0009:16'h000B]}), 16'h0001);
    ctl({1'b1, SRC_EVENT, MODE_PERIODIC, 3'b000});
    snap = o_count_value;
    repeat (3) begin
      evt(1'b1);
      cyc(6);
      evt(1'b0);
      cyc(6);
    end
    chk("ev_clk", o_count_value - snap, 16'h0003);
    poke(K_CMP, 16'h1000);
    poke(K_CNT, 16'h0055);
    ctl({1'b1, SRC_DIV1, MODE_TIMEOUT, 3'b001});
    chk("evsel", 16'({o_edge_select, o_source_select}), 16'h0004);
    evt(1'b1);
    cyc(8);
    chk("to_idle", o_count_value, 16'h0055);
    evt(1'b0);
    cyc(12);
    chk("to_run", 16'(o_run && o_count_value inside {[16'h0006:16'h0008]}), 16'h0001);
    evt(1'b1);
    cyc(8);
    snap = o_count_value;
    poke(K_RUN, 16'h0001);
    poke(K_RDLO, 16'h0000);
    cyc(3);
    chk("to_frz", o_count_value, snap);
    chk("to_frz_r", {o_compare_value[14:0], o_run}, 16'h2000);
    poke(K_CMP, 16'h0008);
    poke(K_CLR, 16'h0003);
    evt(1'b0);
    cyc(20);
    chk("to_top", 16'(o_top_reached_flag), 16'h0001);
    poke(K_CLR, 16'h0003);
    poke(K_CNT, 16'hFFFE);
    wwrap(8);
    chk("to_wrap", 16'(n), 16'h0002);
    chk("to_wrap_ev", 16'(o_wrap_event), 16'h0001);
    ctl({1'b1, SRC_DIV1, MODE_TOP_REACHED_FLAG_EVT, 3'b000});
    poke(K_CNT, 16'h0000);
    poke(K_CLR, 16'h0003);
    evt(1'b1);
    snap = o_count_value + 16'h0004;
    cyc(8);
    chk("top_reached_flag", o_compare_value, snap);
    chk("top_reached_flag_f", 16'(o_top_reached_flag), 16'h0001);
    snap = o_compare_value;
    evt(1'b0);
    cyc(8);
    chk("no_top_reached_flag", o_compare_value, snap);
    poke(K_RDLO, 16'h0000);
    chk("rd_clr", 16'(o_top_reached_flag), 16'h0000);
    ctl({1'b1, SRC_DIV1, MODE_TOP_REACHED_FLAG_EVT, 3'b001});
    evt(1'b1);
    cyc(6);
    evt(1'b0);
    snap = o_count_value + 16'h0004;
    cyc(8);
    chk("top_reached_flag_fall", o_compare_value, snap);
    poke(K_CLR, 16'h0003);
    poke(K_CNT, 16'hFFFE);
    wwrap(8);
    chk("top_reached_flag_wrap", 16'(n), 16'h0002);
    summarize();
  end
endmodule  // tbc_timer_tb_top
